// *** core/tbs_bar_slot.sv ***
`default_nettype none

module tbs_bar_slot #(
  parameter logic ENABLE = 1'b0,
  parameter logic [31:0] SETUP = 32'h0000_0000,
  parameter logic UPPER = 1'b0
) (
  input wire logic clk_i,
  input wire logic rst_i,
  tbs_slot_if.slot bus
);
  import tbs_pkg::*;

  typedef struct packed {
    logic [31:0] base;
  } tbs_slot_state_t;

  localparam logic [31:0] WR_MASK = bar_write_mask(SETUP, UPPER);

  tbs_slot_state_t state_reg;
  tbs_slot_state_t state_next;

  // ---------------------------------------------------------------------------
  // Stored base address
  // ---------------------------------------------------------------------------
  always_comb begin
    state_next = state_reg;
    if (ENABLE && bus.wr) begin
      state_next.base = merge_lanes(state_reg.base, bus.wdat, bus.sel) & WR_MASK;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  // Cleared setup bits are never writable, so a write of all ones reads back
  // the region size; in an enabled slot that is not a high half the type bits show the build setup.
  assign bus.rdat = ENABLE ?
    ((state_reg.base & WR_MASK) | (SETUP & ~WR_MASK)) :
    WORD_ZERO;

endmodule

`default_nettype wire

// *** core/tbs_header_bank.sv ***
// Operation
// - Read-only 8-bit revision byte fixed at build time.
// - Read-only 8-bit self-test byte fixed at build time.
// - Read-only 8-bit header layout byte fixed at build time.
// - Each base address register has its own enable; disabled ones read zero.
// - For 64-bit space registers pair as 0/1, 2/3 and 4/5.
// - Even register of a pair holds low address bits, odd holds high.
// - Bit 0 reads 0 for memory space, 1 for I/O space.
// - Memory bits 2:1 read 00 for 32-bit and 10 for 64-bit space.
// - Memory bit 3 reads 1 when prefetchable, 0 otherwise.
// - Cleared low bits of 31:4 stay zero and give the region size.
// - Optional card information pointer, read-only, zero when not built.
// - Read-only 16-bit subsystem identifier fixed at build time.
//
// The Wishbone register port and the register addresses were left to the implementer.
`default_nettype none

module tbs_header_bank #(
  // Identification values are arbitrary defaults.
  parameter logic [7:0] REVISION = 8'h01,
  parameter logic [7:0] SELF_TEST = 8'h00,
  parameter logic [7:0] HEADER_KIND = 8'h00,
  parameter logic [15:0] SUBSYSTEM_FUNCTION_ID = 16'h0001,
  parameter logic CARD_INFO_ENABLE = 1'b0,
  parameter logic [31:0] CARD_INFO_POINTER = 32'h0000_0000,
  parameter logic [tbs_pkg::BAR_COUNT-1:0] BAR_ENABLE = 6'h01,
  parameter logic [tbs_pkg::BAR_COUNT-1:0][31:0] BAR_SETUP = {6{32'hffff_f000}}
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [tbs_pkg::ADR_WIDTH-1:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o
);
  import tbs_pkg::*;

  typedef struct packed {
    logic ack;
    logic [31:0] rdata;
  } tbs_bank_state_t;

  tbs_bank_state_t state_reg;
  tbs_bank_state_t state_next;
  logic [5:0] word_idx;
  logic commit;
  logic [31:0] slot_rdat [BAR_COUNT];
  logic [31:0] read_word;

  assign word_idx = adr_i[ADR_WORD_MSB:ADR_WORD_LSB];
  // A write lands at the edge where the master sees ack, as classic Wishbone asks.
  assign commit = cyc_i && stb_i && we_i && state_reg.ack;

  // ---------------------------------------------------------------------------
  // Base address register slots
  // ---------------------------------------------------------------------------
  for (genvar i = 0; i < BAR_COUNT; i++) begin : g_bar
    tbs_slot_if port ();
    // Only odd slots can be the high half, and only behind a 64-bit even slot.
    localparam logic UPPER = (i % 2 == 1) ?
        bar_is_upper(BAR_ENABLE[(i/2)*2], BAR_SETUP[(i/2)*2]) : 1'b0;
    assign port.wr = commit && (word_idx == WORD_BAR_FIRST + 6'(i));
    assign port.sel = sel_i;
    assign port.wdat = dat_i;
    assign slot_rdat[i] = port.rdat;
    tbs_bar_slot #(
      .ENABLE(BAR_ENABLE[i]),
      .SETUP(BAR_SETUP[i]),
      .UPPER(UPPER)
    ) u_slot (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .bus(port)
    );
  end

  // ---------------------------------------------------------------------------
  // Read decode
  // ---------------------------------------------------------------------------
  // Unmapped words and the unused bytes of mapped words read as zero; writes
  // to them are acknowledged and dropped.
  always_comb begin
    read_word = WORD_ZERO;
    case (word_idx)
      WORD_REVISION: begin
        read_word[REVISION_LSB +: 8] = REVISION;
      end
      WORD_HEADER: begin
        read_word[HEADER_KIND_LSB +: 8] = HEADER_KIND;
        read_word[SELF_TEST_LSB +: 8] = SELF_TEST;
      end
      WORD_CARD_INFO: begin
        read_word = CARD_INFO_ENABLE ? CARD_INFO_POINTER : WORD_ZERO;
      end
      WORD_SUBSYSTEM: begin
        read_word[SUBSYSTEM_LSB +: 16] = SUBSYSTEM_FUNCTION_ID;
      end
      default: begin
        for (int i = 0; i < BAR_COUNT; i++) begin
          if (word_idx == WORD_BAR_FIRST + 6'(i)) begin
            read_word = slot_rdat[i];
          end
        end
      end
    endcase
  end

  // ---------------------------------------------------------------------------
  // Wishbone answer
  // ---------------------------------------------------------------------------
  // Read-only words have no storage at all, so a write cannot disturb them.
  always_comb begin
    state_next = state_reg;
    state_next.ack = cyc_i && stb_i && !state_reg.ack;
    if (cyc_i && stb_i && !we_i && !state_reg.ack) begin
      state_next.rdata = read_word;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign ack_o = state_reg.ack;
  assign dat_o = state_reg.rdata;

endmodule

`default_nettype wire

// *** core/tbs_pkg.sv ***
`default_nettype none

package tbs_pkg;

  // ---------------------------------------------------------------------------
  // Layout of the header words
  // ---------------------------------------------------------------------------
  localparam int BAR_COUNT = 6;
  localparam int ADR_WIDTH = 8;
  localparam int ADR_WORD_MSB = 7;
  localparam int ADR_WORD_LSB = 2;
  localparam logic [5:0] WORD_REVISION = 6'h02;
  localparam logic [5:0] WORD_HEADER = 6'h03;
  localparam logic [5:0] WORD_BAR_FIRST = 6'h04;
  localparam logic [5:0] WORD_CARD_INFO = 6'h0a;
  localparam logic [5:0] WORD_SUBSYSTEM = 6'h0b;

  localparam int REVISION_LSB = 0;
  localparam int HEADER_KIND_LSB = 16;
  localparam int SELF_TEST_LSB = 24;
  localparam int SUBSYSTEM_LSB = 16;

  localparam logic [31:0] WORD_ZERO = 32'h0000_0000;

  // ---------------------------------------------------------------------------
  // Base address register fields
  // ---------------------------------------------------------------------------
  localparam int BAR_IO_BIT = 0;
  localparam int BAR_TYPE_MSB = 2;
  localparam int BAR_TYPE_LSB = 1;
  localparam int BAR_PREFETCH_BIT = 3;
  localparam logic [1:0] BAR_TYPE_64 = 2'h2;
  localparam logic [31:0] BAR_MEM_FIXED = 32'h0000_000f;
  localparam logic [31:0] BAR_IO_FIXED = 32'h0000_0003;

  // Byte-lane merge of a Wishbone write into a stored word.
  function automatic logic [31:0] merge_lanes(input logic [31:0] old_word,
                                              input logic [31:0] new_word,
                                              input logic [3:0] sel);
    logic [31:0] result;
    result = old_word;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) begin
        result[b*8 +: 8] = new_word[b*8 +: 8];
      end
    end
    return result;
  endfunction

  // Bits that software may write; all other bits read the build setup.
  function automatic logic [31:0] bar_write_mask(input logic [31:0] setup,
                                                 input logic upper);
    logic [31:0] mask;
    mask = setup & ~BAR_MEM_FIXED;
    if (upper) begin
      mask = setup;
    end else if (setup[BAR_IO_BIT]) begin
      mask = setup & ~BAR_IO_FIXED;
    end
    return mask;
  endfunction

  // True when the lower neighbour asks for 64-bit memory space.
  function automatic logic bar_is_upper(input logic lower_enable,
                                        input logic [31:0] lower_setup);
    return lower_enable && !lower_setup[BAR_IO_BIT] &&
           (lower_setup[BAR_TYPE_MSB:BAR_TYPE_LSB] == BAR_TYPE_64);
  endfunction

endpackage

`default_nettype wire

// *** core/tbs_slot_if.sv ***
`default_nettype none

interface tbs_slot_if;
  logic wr;
  logic [3:0] sel;
  logic [31:0] wdat;
  logic [31:0] rdat;

  modport bank (output wr, output sel, output wdat, input rdat);
  modport slot (input wr, input sel, input wdat, output rdat);
endinterface

`default_nettype wire

// *** tb/tbs_header_bank_asserts.sv ***
`default_nettype none
module tbs_header_bank_asserts #(
  parameter logic [7:0] REVISION = 8'h01,
  parameter logic [7:0] SELF_TEST = 8'h00,
  parameter logic [7:0] HEADER_KIND = 8'h00,
  parameter logic [15:0] SUBSYSTEM_FUNCTION_ID = 16'h0001,
  parameter logic [5:0] BAR_ENABLE = 6'h01,
  parameter logic [5:0][31:0] BAR_SETUP = {6{32'hffff_f000}}
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [tbs_pkg::ADR_WIDTH-1:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  input wire logic [31:0] dat_o,
  input wire logic ack_o
);
  import tbs_pkg::*;
  // ----
  // Read handshake
  // ----
  logic rd_t;
  assign rd_t = cyc_i && stb_i && !ack_o && !we_i;
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  sequence s_rd(logic [5:0] w);
    rd_t && adr_i[7:2] == w;
  endsequence
  property p_ack_lat; cyc_i && stb_i && !ack_o |=> ack_o; endproperty
  a_ack_lat: assert property (p_ack_lat) else $error("ack late");
  property p_ack_pulse; ack_o |=> !ack_o; endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack too long");
  property p_rev; s_rd(WORD_REVISION) |=> dat_o[7:0] == REVISION; endproperty
  a_rev: assert property (p_rev) else $error("bad revision");
  property p_self; s_rd(WORD_HEADER) |=> dat_o[31:24] == SELF_TEST; endproperty
  a_self: assert property (p_self) else $error("bad self test");
  property p_hdr; s_rd(WORD_HEADER) |=> dat_o[23:16] == HEADER_KIND; endproperty
  a_hdr: assert property (p_hdr) else $error("bad header kind");
  property p_sub; s_rd(WORD_SUBSYSTEM) |=> dat_o[31:16] == SUBSYSTEM_FUNCTION_ID; endproperty
  a_sub: assert property (p_sub) else $error("bad subsystem");
  property p_bar0;
    s_rd(WORD_BAR_FIRST) |=> dat_o[3:0] == (BAR_ENABLE[0] ? BAR_SETUP[0][3:0] : 4'h0);
  endproperty
  a_bar0: assert property (p_bar0) else $error("bad type bits");
  property p_dis;
    s_rd(WORD_BAR_FIRST + 6'h5) ##0 (BAR_ENABLE[5] == 1'b0) |=> dat_o == WORD_ZERO;
  endproperty
  a_dis: assert property (p_dis) else $error("disabled bar not zero");
  property p_unmap; s_rd(6'h0c) |=> dat_o == WORD_ZERO; endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped not zero");
endmodule
bind tbs_header_bank tbs_header_bank_asserts #(.REVISION(REVISION), .SELF_TEST(SELF_TEST),
  .HEADER_KIND(HEADER_KIND), .SUBSYSTEM_FUNCTION_ID(SUBSYSTEM_FUNCTION_ID), .BAR_ENABLE(BAR_ENABLE),
  .BAR_SETUP(BAR_SETUP)) tbs_header_bank_asserts_inst (.clk_i(clk_i), .rst_i(rst_i),
  .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i),
  .dat_o(dat_o), .ack_o(ack_o));
`default_nettype wire

// *** tb/tbs_host_model.sv ***
`default_nettype none
module tbs_host_model (
  input wire logic clk_i,
  input wire logic ack_i,
  input wire logic [31:0] dat_i,
  output logic cyc_o,
  output logic stb_o,
  output logic we_o,
  output logic [7:0] adr_o,
  output logic [3:0] sel_o,
  output logic [31:0] dat_o
);
  initial {cyc_o, stb_o, we_o, adr_o, sel_o, dat_o} = '0;
  // ----
  // One classic cycle; the request stands until ack is sampled.
  // ----
  task automatic xfer(input logic w, input logic [7:0] a, input logic [3:0] s,
                      input logic [31:0] d, output logic [31:0] q);
    @(posedge clk_i);
    {cyc_o, stb_o, we_o, adr_o, sel_o, dat_o} <= {2'b11, w, a, s, d};
    do @(posedge clk_i); while (ack_i !== 1'b1);
    q = dat_i;
    {cyc_o, stb_o} <= 2'b00;
  endtask
endmodule
`default_nettype wire

// *** tb/testbench.sv ***
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 100ps;
  import tbs_pkg::*;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc, stb, we, ack;
  logic [7:0] adr;
  logic [3:0] sel;
  logic [31:0] wdat, rdat, q;
  int n_fail = 0;
  int checked = 0;
  // Build values of the bench; the identification values are arbitrary.
  localparam logic [7:0] TB_REVISION = 8'h5a;
  localparam logic [7:0] TB_SELF_TEST = 8'h80;
  localparam logic [15:0] TB_SUBSYSTEM = 16'h1234;
  localparam logic CARD_ON = 1'b1;
  localparam logic [31:0] TB_CARD_INFO = 32'h0000_0040;
  localparam logic [5:0] BAR_ON = 6'h1f;
  // Region 0 asks for 64-bit space, so region 1 is its high half; region 2 is I/O.
  localparam logic [5:0][31:0] BAR_BUILD = {32'hffff_f000, 32'hffff_f000, 32'hfff0_0008,
    32'hffff_ff01, 32'hffff_ffff, 32'hffff_f004};
  // Words 0x30 down to 0x08; the first listed is the unmapped word.
  localparam logic [10:0][31:0] EXP0 = {32'h0, {TB_SUBSYSTEM, 16'h0}, TB_CARD_INFO, 32'h0,
    32'h0, 32'h8, 32'h1, 32'h0, 32'h4, {TB_SELF_TEST, 24'h0}, {24'h0, TB_REVISION}};
  localparam logic [10:0][31:0] EXP1 = {32'h0, {TB_SUBSYSTEM, 16'h0}, TB_CARD_INFO, 32'h0,
    32'hffff_f000, 32'hfff0_0008, 32'hffff_ff01, 32'hffff_ffff, 32'hffff_f004,
    {TB_SELF_TEST, 24'h0}, {24'h0, TB_REVISION}};
  tbs_header_bank #(.REVISION(TB_REVISION), .SELF_TEST(TB_SELF_TEST),
    .SUBSYSTEM_FUNCTION_ID(TB_SUBSYSTEM), .CARD_INFO_ENABLE(CARD_ON), .CARD_INFO_POINTER(TB_CARD_INFO),
    .BAR_ENABLE(BAR_ON), .BAR_SETUP(BAR_BUILD)) tbs_header_bank_inst (.clk_i(clk_i),
    .rst_i(rst_i),
    .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr), .sel_i(sel), .dat_i(wdat),
    .dat_o(rdat), .ack_o(ack));
  tbs_host_model tbs_host_model_inst (.clk_i(clk_i), .ack_i(ack), .dat_i(rdat),
    .cyc_o(cyc), .stb_o(stb), .we_o(we), .adr_o(adr), .sel_o(sel), .dat_o(wdat));
  task automatic cmp(input string nm, input logic [31:0] e, input logic [31:0] s);
    checked++;
    if (s !== e) begin
      n_fail++;
      $display("mismatch %s exp %h got %h", nm, e, s);
    end
  endtask
  task automatic end_sim();
    $display("checked %0d n_fail %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  initial forever #2.5 clk_i = ~clk_i;
  // The tests take about 190 cycles, so this leaves a wide margin.
  initial begin
    #20000;
    n_fail++;
    end_sim();
  end
  initial begin
    string nm;
    logic [31:0] e;
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    // Pass 0 reads reset values, pass 1 writes ones, pass 2 writes zeros.
    for (int p = 0; p < 3; p++) begin
      for (int k = 0; k < 11; k++) begin
        nm = $sformatf("word %0d", k + 2);
        e = (p == 1) ? EXP1[k] : EXP0[k];
        if (p > 0) begin
          tbs_host_model_inst.xfer(1'b1, 8'(k * 4 + 8), 4'hf, {32{p == 1}}, q);
        end
        tbs_host_model_inst.xfer(1'b0, 8'(k * 4 + 8), 4'hf, 32'h0, q);
        if (k < 2) begin
          cmp(nm, e, q);
        end else if (k < 8) begin
          cmp(nm, e, q);
        end else begin
          cmp(nm, e, q);
        end
      end
      $display("test pass %0d done", p);
    end
    tbs_host_model_inst.xfer(1'b1, 8'h20, 4'h2, 32'hffff_ffff, q);
    tbs_host_model_inst.xfer(1'b0, 8'h20, 4'hf, 32'h0, q);
    cmp("lane write", 32'h0000_f000, q);
    $display("test lanes done");
    // A reset in mid-run must clear the stored high half and the read data register.
    tbs_host_model_inst.xfer(1'b1, 8'h14, 4'hf, 32'hffff_ffff, q);
    tbs_host_model_inst.xfer(1'b0, 8'h14, 4'hf, 32'h0, q);
    cmp("high half before reset", 32'hffff_ffff, q);
    @(posedge clk_i);
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    cmp("read data after reset", WORD_ZERO, rdat);
    tbs_host_model_inst.xfer(1'b0, 8'h14, 4'hf, 32'h0, q);
    cmp("high half after reset", WORD_ZERO, q);
    $display("test reset done");
    end_sim();
  end
endmodule
`default_nettype wire
